// ===== hdl/fsp_consts.vh
// constants for the flash status and protection register bank
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH
// status word bit positions
`define FSP_B_BUSY 0
`define FSP_B_WPL 1
`define FSP_B_GUARD_LO 2
`define FSP_B_GUARD_HI 6
`define FSP_B_LOCK_LOW 7
`define FSP_B_LOCK_HIGH 8
`define FSP_B_FOUR_LINE 9
`define FSP_B_PROG_PAUSED 10
`define FSP_B_INFO_LO 11
`define FSP_B_INFO_HI 13
`define FSP_B_INVERT 14
`define FSP_B_ERASE_PAUSED 15
`define FSP_B_WAIT_LO 16
`define FSP_B_WAIT_HI 17
`define FSP_B_GUARD_ERR 18
`define FSP_B_CYCLE_FAIL 19
`define FSP_B_DRIVE_LO 21
`define FSP_B_DRIVE_HI 22
`define FSP_B_PIN_SEL 23
// bits a status write may change (byte 1, 2, 3 in order)
`define FSP_WR_MASK 24'he37bfc
// factory defaults: drive level code 10, all else zero
`define FSP_STATUS_RST 24'h400000
// serial command codes
`define FSP_CMD_WR_PERMIT 8'h06
`define FSP_CMD_WR_FORBID 8'h04
`define FSP_CMD_VOL_PERMIT 8'h50
`define FSP_CMD_STATUS_WR 8'h01
`define FSP_CMD_VOL_LOCK_WR 8'hc0
`define FSP_CMD_RD_BYTE1 8'h05
`define FSP_CMD_RD_BYTE2 8'h35
`define FSP_CMD_RD_BYTE3 8'h15
// protect modes
`define FSP_MODE_SOFT 2'h0
`define FSP_MODE_PIN 2'h1
`define FSP_MODE_SUPPLY 2'h2
`define FSP_MODE_OTP 2'h3
`endif

// ===== hdl/fsp_region_check.v
// guarded-region decoder for the block-protection and invert bits
`timescale 1ns/10ps
module fsp_region_check
(
	input wire [4:0] i_guard,
	input wire i_invert,
	input wire [23:0] i_addr,
	output reg o_guarded
);
	reg [4:0] shift;
	reg [24:0] span;
	reg [23:0] mask;
	reg hit;

	// region size and side from the guard code, inversion from the invert bit
	always @*
	begin
		shift = 5'h00;
		span = 25'h0000000;
		mask = 24'h000000;
		hit = 1'b0;
		if (i_guard[4])
			shift = (i_guard[2:0] > 3'h4) ? 5'h0f : (5'h0b + {2'h0, i_guard[2:0]});
		else
			shift = 5'h11 + {2'h0, i_guard[2:0]};
		span = 25'h0000001 << shift;
		mask = ~(span[23:0] - 24'h000001);
		if (i_guard[2:0] == 3'h0)
			hit = 1'b0;
		else if (i_guard[2:0] == 3'h7)
			hit = 1'b1;
		else if (i_guard[3])
			hit = ((i_addr & mask) == 24'h000000); // lower or bottom
		else
			hit = ((i_addr & mask) == mask); // upper or top
		o_guarded = hit ^ i_invert;
	end
endmodule // fsp_region_check

// ===== hdl/fsp_status_bank.v
// status and protection configuration bank behind the serial pins
`timescale 1ns/10ps
`include "fsp_consts.vh"

// Overview of operation
// - Program or erase inside the guarded region is refused, array untouched.
// - Whole-array erase is ignored unless all five guard bits are zero.
// - Four-line enable 0: pins are write-protect and hold/reset; 1: data lines.
// - Program suspend sets program-paused flag; program resume clears it.
// - Erase suspend sets erase-paused flag; erase resume clears it.
// - Info-area lock bits default 0, once set stay set and block programming.
// - Invert bit sits at bit 14, default 0, joins guard bits.
// - Wait-cycle bits give 6,4,8,10 and 10,8,4,6 dummy cycles.
// - Guard error set on refused program or erase; cleared only by resets.
// - Write-cycle failure flag set when a program or erase failed.
// - Drive level codes 00..11 give 100, 75, 50 (default), 25 percent.
// - Bit 23 picks hold or reset role, only while four-line enable 0.
// - Lock mode 00: status write needs write-permit latch only.
// - Lock mode 01: locked while protect pin low, else latch needed.
// - Lock mode 10: no status writes until power cycle, which gives 00.
// - Lock mode 11: status writes rejected for good.
// - Volatile lock-mode write needs no write-permit command.
// - Invert 0: guard codes select top or bottom regions, 111 all.
// - Invert 1: protected region is the complement of the invert-0 region.
// - Latch set by permit, cleared by forbid and after writes or operations.
module fsp_status_bank
(
	input wire i_clk_sys,
	input wire i_reset,
	input wire i_power_cycle,
	input wire i_sw_reset,
	input wire i_sck,
	input wire i_cs_n,
	input wire i_si,
	output reg o_so,
	output reg o_so_oe,
	input wire i_wp_n,
	input wire i_hold_reset_n,
	input wire i_op_req,
	input wire i_op_erase,
	input wire i_op_whole,
	input wire [23:0] i_op_addr,
	output reg o_op_grant,
	output reg o_op_refused,
	input wire i_op_done,
	input wire i_op_fail,
	input wire i_array_busy,
	input wire i_suspend,
	input wire i_resume,
	input wire i_info_req,
	input wire [1:0] i_info_sel,
	output reg o_info_grant,
	output reg o_info_refused,
	output wire o_wp_pin_active,
	output wire o_hold_active,
	output wire o_reset_pin_active,
	output wire o_four_line_data,
	output wire o_hold_n,
	output reg [3:0] o_wait_cycles_eb,
	output reg [3:0] o_wait_cycles_ed,
	output reg [1:0] o_drive_level,
	output reg [6:0] o_drive_pct,
	output wire [23:0] o_status
);
	localparam ST_CMD = 2'h0;
	localparam ST_WRITE = 2'h1;
	localparam ST_READ = 2'h2;
	localparam ST_SKIP = 2'h3;

	// dummy cycles for the first quad read command
	function [3:0] fsp_wait_eb;
		input [1:0] code;
		begin
			case (code)
				2'h0: fsp_wait_eb = 4'h6;
				2'h1: fsp_wait_eb = 4'h4;
				2'h2: fsp_wait_eb = 4'h8;
				default: fsp_wait_eb = 4'ha;
			endcase
		end
	endfunction

	// dummy cycles for the second quad read command
	function [3:0] fsp_wait_ed;
		input [1:0] code;
		begin
			case (code)
				2'h0: fsp_wait_ed = 4'ha;
				2'h1: fsp_wait_ed = 4'h8;
				2'h2: fsp_wait_ed = 4'h4;
				default: fsp_wait_ed = 4'h6;
			endcase
		end
	endfunction

	reg [23:0] status;
	reg vol_permit;
	reg [1:0] state;
	reg [2:0] bit_cnt;
	reg [1:0] byte_cnt;
	reg [7:0] shift_in;
	reg [7:0] shift_out;
	reg [7:0] cmd;
	reg [23:0] wr_data;
	reg cur_erase;
	reg [2:0] sck_sync;
	reg [2:0] cs_sync;
	reg [1:0] si_sync;
	reg [1:0] wp_sync;
	reg [2:0] hr_sync;
	reg [23:0] next_status;
	reg [23:0] wr_mask;
	reg [1:0] next_lock;
	wire sck_rise;
	wire sck_fall;
	wire cs_rise;
	wire cs_fall;
	wire [7:0] byte_now;
	wire [1:0] lock_mode;
	wire wp_level;
	wire write_open;
	wire pin_reset;
	wire flag_reset;
	wire guarded;
	wire op_block;

	// two-stage synchronisers, third stage only for edge finding
	always @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			sck_sync <= 3'h0;
			cs_sync <= 3'h7;
			si_sync <= 2'h0;
			wp_sync <= 2'h3;
			hr_sync <= 3'h7;
		end
		else
		begin
			sck_sync <= {sck_sync[1:0], i_sck};
			cs_sync <= {cs_sync[1:0], i_cs_n};
			si_sync <= {si_sync[0], i_si};
			wp_sync <= {wp_sync[0], i_wp_n};
			hr_sync <= {hr_sync[1:0], i_hold_reset_n};
		end
	end

	assign sck_rise = sck_sync[1] & ~sck_sync[2] & ~cs_sync[1];
	assign sck_fall = ~sck_sync[1] & sck_sync[2] & ~cs_sync[1];
	assign cs_rise = cs_sync[1] & ~cs_sync[2];
	assign cs_fall = ~cs_sync[1] & cs_sync[2];
	assign byte_now = {shift_in[6:0], si_sync[1]};
	assign lock_mode = {status[`FSP_B_LOCK_HIGH], status[`FSP_B_LOCK_LOW]};

	// shared pin roles follow four-line enable and the pin select bit
	assign o_four_line_data = status[`FSP_B_FOUR_LINE];
	assign o_wp_pin_active = ~status[`FSP_B_FOUR_LINE];
	assign o_hold_active = ~status[`FSP_B_FOUR_LINE] & ~status[`FSP_B_PIN_SEL];
	assign o_reset_pin_active = ~status[`FSP_B_FOUR_LINE] & status[`FSP_B_PIN_SEL];
	assign o_hold_n = ~(o_hold_active & ~hr_sync[1]);
	assign pin_reset = o_reset_pin_active & ~hr_sync[1] & hr_sync[2];
	assign flag_reset = i_sw_reset | pin_reset | i_power_cycle;
	// protect pin is a data line in four-line mode, seen as high then
	assign wp_level = wp_sync[1] | status[`FSP_B_FOUR_LINE];

	// status writes allowed only in the open protect modes
	assign write_open = (lock_mode == `FSP_MODE_SOFT) |
		((lock_mode == `FSP_MODE_PIN) & wp_level);

	fsp_region_check u_region
	(
		.i_guard(status[`FSP_B_GUARD_HI:`FSP_B_GUARD_LO]),
		.i_invert(status[`FSP_B_INVERT]),
		.i_addr(i_op_addr),
		.o_guarded(guarded)
	);

	// whole-array erase needs all guard bits clear, others a clear region
	assign op_block = i_op_whole ?
		(status[`FSP_B_GUARD_HI:`FSP_B_GUARD_LO] != 5'h00) :
		guarded;

	// merge of received status bytes, information locks one-way only
	always @*
	begin
		wr_mask = `FSP_WR_MASK;
		if (byte_cnt < 2'h3)
			wr_mask[23:16] = 8'h00;
		if (byte_cnt < 2'h2)
			wr_mask[15:8] = 8'h00;
		next_status = (status & ~wr_mask) | (wr_data & wr_mask);
		next_status[`FSP_B_INFO_HI:`FSP_B_INFO_LO] =
			status[`FSP_B_INFO_HI:`FSP_B_INFO_LO] |
			next_status[`FSP_B_INFO_HI:`FSP_B_INFO_LO];
	end

	// serial command engine, bytes taken on sampled clock rises
	always @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			state <= ST_CMD;
			bit_cnt <= 3'h0;
			byte_cnt <= 2'h0;
			shift_in <= 8'h00;
			cmd <= 8'h00;
			wr_data <= 24'h000000;
		end
		else if (cs_sync[1])
		begin
			state <= ST_CMD;
			bit_cnt <= 3'h0;
			if (cs_rise)
				byte_cnt <= byte_cnt;
			else
				byte_cnt <= 2'h0;
		end
		else if (sck_rise)
		begin
			shift_in <= byte_now;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7)
			begin
				case (state)
					ST_CMD:
					begin
						cmd <= byte_now;
						byte_cnt <= 2'h0;
						if (byte_now == `FSP_CMD_STATUS_WR ||
							byte_now == `FSP_CMD_VOL_LOCK_WR)
							state <= ST_WRITE;
						else if (byte_now == `FSP_CMD_RD_BYTE1 ||
							byte_now == `FSP_CMD_RD_BYTE2 ||
							byte_now == `FSP_CMD_RD_BYTE3)
							state <= ST_READ;
						else
							state <= ST_SKIP;
					end
					ST_WRITE:
					begin
						case (byte_cnt)
							2'h0: wr_data[7:0] <= byte_now;
							2'h1: wr_data[15:8] <= byte_now;
							default: wr_data[23:16] <= byte_now;
						endcase
						if (byte_cnt == 2'h2 || cmd == `FSP_CMD_VOL_LOCK_WR)
							state <= ST_SKIP;
						byte_cnt <= byte_cnt + 2'h1;
					end
					default: state <= state;
				endcase
			end
		end
	end

	// read data shifted out on falling clock edges, msb first
	always @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			shift_out <= 8'h00;
			o_so <= 1'b0;
			o_so_oe <= 1'b0;
		end
		else if (cs_sync[1])
		begin
			o_so_oe <= 1'b0;
			o_so <= 1'b0;
		end
		else if (state == ST_READ && sck_fall)
		begin
			o_so_oe <= 1'b1;
			if (bit_cnt == 3'h0)
			begin
				case (cmd)
					`FSP_CMD_RD_BYTE1: shift_out <= {status[7:1], i_array_busy} << 1;
					`FSP_CMD_RD_BYTE2: shift_out <= status[15:8] << 1;
					default: shift_out <= status[23:16] << 1;
				endcase
				case (cmd)
					`FSP_CMD_RD_BYTE1: o_so <= status[7];
					`FSP_CMD_RD_BYTE2: o_so <= status[15];
					default: o_so <= status[23];
				endcase
			end
			else
			begin
				o_so <= shift_out[7];
				shift_out <= shift_out << 1;
			end
		end
	end

	// status word, latches and flags
	always @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			status <= `FSP_STATUS_RST;
			vol_permit <= 1'b0;
			cur_erase <= 1'b0;
		end
		else
		begin
			// write-permit latch commands on chip-select release
			if (cs_rise && state == ST_SKIP && bit_cnt == 3'h0)
			begin
				if (cmd == `FSP_CMD_WR_PERMIT)
					status[`FSP_B_WPL] <= 1'b1;
				if (cmd == `FSP_CMD_WR_FORBID)
					status[`FSP_B_WPL] <= 1'b0;
				if (cmd == `FSP_CMD_VOL_PERMIT)
					vol_permit <= 1'b1;
			end
			// status write commits only whole bytes at chip-select release
			if (cs_rise && bit_cnt == 3'h0 && byte_cnt != 2'h0 &&
				cmd == `FSP_CMD_STATUS_WR && !i_array_busy)
			begin
				if (write_open && (status[`FSP_B_WPL] || vol_permit))
				begin
					status[23:2] <= next_status[23:2];
					if (!vol_permit)
						status[`FSP_B_WPL] <= 1'b0;
				end // else unchanged
				vol_permit <= 1'b0;
			end
			// volatile lock-mode write, no latch needed
			if (cs_rise && bit_cnt == 3'h0 && byte_cnt != 2'h0 &&
				cmd == `FSP_CMD_VOL_LOCK_WR && write_open)
			begin
				status[`FSP_B_LOCK_LOW] <= wr_data[0];
				status[`FSP_B_LOCK_HIGH] <= wr_data[1];
			end
			// resets clear volatile flags after the permit sets and ahead of the flag sets below, so only those flag sets win
			if (flag_reset)
			begin
				status[`FSP_B_WPL] <= 1'b0;
				status[`FSP_B_PROG_PAUSED] <= 1'b0;
				status[`FSP_B_ERASE_PAUSED] <= 1'b0;
				status[`FSP_B_GUARD_ERR] <= 1'b0;
				status[`FSP_B_CYCLE_FAIL] <= 1'b0;
				vol_permit <= 1'b0;
			end
			// array operation request: refuse or grant
			if (i_op_req && op_block)
				status[`FSP_B_GUARD_ERR] <= 1'b1;
			if (i_op_req && !op_block)
				cur_erase <= i_op_erase;
			if (i_op_done)
			begin
				status[`FSP_B_WPL] <= 1'b0;
				if (i_op_fail)
					status[`FSP_B_CYCLE_FAIL] <= 1'b1;
			end
			// resume before suspend, so a same-cycle suspend wins
			if (i_resume)
			begin
				if (status[`FSP_B_PROG_PAUSED])
					status[`FSP_B_PROG_PAUSED] <= 1'b0;
				else
					status[`FSP_B_ERASE_PAUSED] <= 1'b0;
			end
			if (i_suspend && i_array_busy)
			begin
				if (cur_erase)
					status[`FSP_B_ERASE_PAUSED] <= 1'b1;
				else
					status[`FSP_B_PROG_PAUSED] <= 1'b1;
			end
			// power cycle also ends supply lock
			if (i_power_cycle && lock_mode == `FSP_MODE_SUPPLY)
			begin
				status[`FSP_B_LOCK_LOW] <= 1'b0;
				status[`FSP_B_LOCK_HIGH] <= 1'b0;
			end
		end
	end

	// grant answers for array and information-area requests
	always @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			o_op_grant <= 1'b0;
			o_op_refused <= 1'b0;
			o_info_grant <= 1'b0;
			o_info_refused <= 1'b0;
		end
		else
		begin
			o_op_grant <= i_op_req & ~op_block;
			o_op_refused <= i_op_req & op_block;
			o_info_grant <= i_info_req & (i_info_sel != 2'h3) &
				~status[`FSP_B_INFO_LO + i_info_sel];
			o_info_refused <= i_info_req & ((i_info_sel == 2'h3) |
				status[`FSP_B_INFO_LO + i_info_sel]);
		end
	end

	// read configuration decoded from the nonvolatile fields
	always @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			o_wait_cycles_eb <= 4'h6;
			o_wait_cycles_ed <= 4'ha;
			o_drive_level <= 2'h2;
			o_drive_pct <= 7'h32;
		end
		else
		begin
			o_wait_cycles_eb <= fsp_wait_eb(status[17:16]);
			o_wait_cycles_ed <= fsp_wait_ed(status[17:16]);
			o_drive_level <= status[22:21];
			case (status[22:21])
				2'h0: o_drive_pct <= 7'h64;
				2'h1: o_drive_pct <= 7'h4b;
				2'h2: o_drive_pct <= 7'h32;
				default: o_drive_pct <= 7'h19;
			endcase
		end
	end

	assign o_status = {status[23:1], i_array_busy};
endmodule // fsp_status_bank

// ===== verif/fsp_status_bank_properties.sv
// concurrent checks on the status bank ports
`timescale 1ns/10ps
module fsp_status_bank_props
(
	input wire i_clk_sys,
	input wire i_reset,
	input wire i_power_cycle,
	input wire i_sw_reset,
	input wire i_op_req,
	input wire i_op_whole,
	input wire o_op_grant,
	input wire o_op_refused,
	input wire o_wp_pin_active,
	input wire o_hold_active,
	input wire o_reset_pin_active,
	input wire o_four_line_data,
	input wire [3:0] o_wait_cycles_eb,
	input wire [6:0] o_drive_pct,
	input wire [23:0] o_status
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);
	// answers, flags and pin roles tied to their causes
	chk_answer_once: assert property (i_op_req && !i_op_whole
		|=> o_op_grant != o_op_refused) else $error("no single answer");
	chk_refuse_flag: assert property (o_op_refused |-> o_status[18])
		else $error("refusal without guard error");
	chk_whole_guarded: assert property (i_op_req && i_op_whole
		&& o_status[6:2] != 5'h0 |=> !o_op_grant)
		else $error("whole erase granted");
	chk_four_line: assert property (o_four_line_data == o_status[9]
		&& o_wp_pin_active == !o_status[9]) else $error("four-line pins wrong");
	chk_pin_role: assert property ({o_hold_active, o_reset_pin_active} ==
		({2{!o_status[9]}} & {!o_status[23], o_status[23]}))
		else $error("pin role wrong");
	chk_wait_code: assert property ($stable(o_status[17:16]) [*2] |->
		o_wait_cycles_eb == 4'(16'ha846 >> {o_status[17:16], 2'h0}))
		else $error("wait cycles wrong");
	chk_drive_code: assert property ($stable(o_status[22:21]) [*2] |->
		o_drive_pct == 7'h64 - 7'h19 * {5'h0, o_status[22:21]})
		else $error("drive percent wrong");
	chk_info_sticky: assert property (
		($past(o_status[13:11]) & ~o_status[13:11]) == 3'h0)
		else $error("info lock cleared");
	chk_err_hold: assert property ($fell(o_status[18]) |-> $past(i_reset)
		|| $past(i_sw_reset) || $past(i_power_cycle) || o_reset_pin_active)
		else $error("guard error cleared");
	chk_lock_freeze: assert property (o_status[8] && !i_power_cycle |=>
		(o_status & 24'he37bfc) == ($past(o_status) & 24'he37bfc))
		else $error("locked word changed");
	// main scenarios
	cov_refused: cover property (o_op_refused);
	cov_supply_lock: cover property (o_status[8:7] == 2'h2);
	cov_four_line: cover property (o_four_line_data);
endmodule // fsp_status_bank_props
bind fsp_status_bank fsp_status_bank_props u_props (.i_clk_sys, .i_reset,
	.i_power_cycle, .i_sw_reset, .i_op_req, .i_op_whole, .o_op_grant,
	.o_op_refused, .o_wp_pin_active, .o_hold_active, .o_reset_pin_active,
	.o_four_line_data, .o_wait_cycles_eb, .o_drive_pct, .o_status);

// ===== verif/fsp_host_model.sv
// serial host model in mode 0 for the status bank link
`timescale 1ns/10ps
module fsp_host_model
(
	output reg o_sck,
	output reg o_cs_n,
	output reg o_si,
	input wire i_so
);
	// idle: clock low, not selected
	initial
	begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	// one frame msb first, bytes 1..3 of wd in order, optional read byte
	task frame(input [7:0] cmd, input integer nb, input [23:0] wd,
		input rd_en, output [7:0] rd);
		reg [31:0] sh;
		integer i;
	begin
		sh = {cmd, wd[7:0], wd[15:8], wd[23:16]};
		rd = 8'h00;
		#5 o_cs_n = 1'b0;
		for (i = 0; i < 8 * nb + 8; i = i + 1)
		begin
			o_si = sh[31];
			sh = sh << 1;
			#32 o_sck = 1'b1;
			#32 o_sck = 1'b0;
		end
		// released line shows the inverse of its last bit
		o_si = ~o_si;
		for (i = 0; i < 8 * rd_en; i = i + 1)
		begin
			#32 o_sck = 1'b1;
			#28 rd = {rd[6:0], i_so}; // late sample covers sync delay
			#4 o_sck = 1'b0;
		end
		#32 o_cs_n = 1'b1;
		#403 o_si = ~o_si;
	end
	endtask
endmodule // fsp_host_model

// ===== verif/fsp_status_bank_tb.sv
// self-checking bench for the status and protection bank
`timescale 1ns/10ps
`include "fsp_consts.vh"
module fsp_status_bank_tb;
	reg i_clk_sys, i_reset, i_wp_n, i_hold_reset_n, i_op_req, i_op_erase;
	reg i_op_whole, i_array_busy, i_info_req;
	reg [1:0] i_info_sel;
	reg [5:0] ev;
	reg [23:0] i_op_addr, a;
	reg [7:0] rd;
	reg [3:0] exp_q[$];
	integer n_fail, check_count, seed, cyc, k;
	wire i_op_done, i_op_fail, i_power_cycle, i_resume, i_suspend, i_sw_reset;
	wire sck, cs_n, si, o_so, o_so_oe, o_op_grant, o_op_refused, o_info_grant;
	wire o_info_refused, o_wp_pin_active, o_hold_active, o_reset_pin_active;
	wire o_four_line_data, o_hold_n;
	wire [3:0] o_wait_cycles_eb, o_wait_cycles_ed;
	wire [1:0] o_drive_level;
	wire [6:0] o_drive_pct;
	wire [23:0] o_status;
	// event pulses share one vector
	assign {i_op_done, i_op_fail, i_power_cycle, i_resume, i_suspend,
		i_sw_reset} = ev;
	fsp_status_bank u_dut (.i_clk_sys, .i_reset, .i_power_cycle, .i_sw_reset,
		.i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so, .o_so_oe, .i_wp_n,
		.i_hold_reset_n, .i_op_req, .i_op_erase, .i_op_whole, .i_op_addr,
		.o_op_grant, .o_op_refused, .i_op_done, .i_op_fail, .i_array_busy,
		.i_suspend, .i_resume, .i_info_req, .i_info_sel, .o_info_grant,
		.o_info_refused, .o_wp_pin_active, .o_hold_active, .o_reset_pin_active,
		.o_four_line_data, .o_hold_n, .o_wait_cycles_eb, .o_wait_cycles_ed,
		.o_drive_level, .o_drive_pct, .o_status);
	fsp_host_model u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(o_so));
	task cmp_val(input string nm, input [23:0] e, input [23:0] s);
	begin
		check_count = check_count + 1;
		if (s !== e)
		begin
			n_fail = n_fail + 1;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	end
	endtask
	task cmp_ans(input [3:0] e, input [3:0] s);
	begin
		cmp_val("answer", {20'h0, e}, {20'h0, s});
	end
	endtask
	task cmp_pins(input [3:0] e);
	begin
		cmp_val("pins", {20'h0, e}, {20'h0, o_four_line_data, o_wp_pin_active,
			o_hold_active, o_reset_pin_active});
	end
	endtask
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task spi(input [7:0] c, input integer nb, input [23:0] wd);
	begin
		u_host.frame(c, nb, wd, 1'b0, rd);
	end
	endtask
	// latch-based write of the whole word
	task wr(input [23:0] wd);
	begin
		spi(`FSP_CMD_WR_PERMIT, 0, 24'h0);
		spi(`FSP_CMD_STATUS_WR, 3, wd);
	end
	endtask
	// array or info request; answer noted as {grant, refused, igrant, irefused}
	task ask(input info, input er, input wh, input [23:0] ad, input [3:0] e);
	begin
		if (e != 4'h0)
			exp_q.push_back(e);
		@(posedge i_clk_sys);
		i_op_req <= !info;
		i_info_req <= info;
		i_op_erase <= er;
		i_op_whole <= wh;
		i_op_addr <= ad;
		i_info_sel <= ad[1:0];
		@(posedge i_clk_sys);
		i_op_req <= 1'b0;
		i_info_req <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
	end
	endtask
	task pulse(input [5:0] e);
	begin
		@(posedge i_clk_sys);
		ev <= e;
		@(posedge i_clk_sys);
		ev <= 6'h0;
		repeat (3) @(posedge i_clk_sys);
	end
	endtask
	// watcher: each answer pulse takes the oldest note
	always @(posedge i_clk_sys)
	begin
		if (o_op_grant | o_op_refused | o_info_grant | o_info_refused)
		begin
			if (exp_q.size() > 0)
				cmp_ans(exp_q.pop_front(), {o_op_grant, o_op_refused,
					o_info_grant, o_info_refused});
			else if (o_op_grant | o_info_grant)
				cmp_ans(4'h0, {o_op_grant, 1'b0, o_info_grant, 1'b0});
		end
	end
	initial
	begin
		i_clk_sys = 1'b0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end
	// hang guard
	always @(posedge i_clk_sys)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			n_fail = n_fail + 1;
			tally_and_finish;
		end
	end
	initial
	begin
		seed = 32'hc0c2;
		{n_fail, check_count, cyc} = 96'h0;
		{ev, i_op_req, i_op_erase, i_op_whole, i_array_busy, i_info_req} = 11'h0;
		{i_reset, i_wp_n, i_hold_reset_n} = 3'h7;
		i_info_sel = 2'h0;
		i_op_addr = 24'h0;
		repeat (16) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		cmp_val("status", `FSP_STATUS_RST, o_status);
		cmp_pins(4'h6);
		i_hold_reset_n <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		cmp_val("hold", 24'h0, {23'h0, o_hold_n});
		i_hold_reset_n <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		u_host.frame(`FSP_CMD_RD_BYTE3, 0, 24'h0, 1'b1, rd);
		cmp_val("byte3", 24'h40, {16'h0, rd});
		cmp_val("so oe", 24'h0, {23'h0, o_so_oe});
		ask(0, 1, 1, 24'h0, 4'h8);
		pulse(6'h20);
		// every wait-cycle and drive code
		for (k = 0; k < 4; k = k + 1)
		begin
			wr({1'b0, k[1:0], 3'h0, k[1:0], 16'h0});
			a = 24'(16'ha846 >> 4 * k) & 24'hf;
			cmp_val("eb", a, {20'h0, o_wait_cycles_eb});
			a = 24'(16'h648a >> 4 * k) & 24'hf;
			cmp_val("ed", a, {20'h0, o_wait_cycles_ed});
			cmp_val("pct", 24'(32'h64 - 32'h19 * k), {17'h0, o_drive_pct});
			cmp_val("level", {22'h0, k[1:0]}, {22'h0, o_drive_level});
			cmp_val("wpl", 24'h0, {23'h0, o_status[1]});
		end
		spi(`FSP_CMD_STATUS_WR, 3, 24'h000004);
		cmp_val("cfg", 24'h630000, o_status & 24'he37bfc);
		// top 256 KB guarded, then inverted
		wr(24'h000004);
		a = 24'hfc0000 | (24'($random(seed)) & 24'h03ffff);
		ask(0, 0, 0, a, 4'h4);
		cmp_val("guard err", 24'h1, {23'h0, o_status[18]});
		ask(0, 1, 0, 24'hfbffff, 4'h8);
		pulse(6'h20);
		ask(0, 1, 1, 24'h0, 4'h4);
		pulse(6'h01);
		cmp_val("guard err", 24'h0, {23'h0, o_status[18]});
		wr(24'h004004);
		ask(0, 0, 0, a & 24'h03ffff, 4'h4);
		ask(0, 0, 0, a, 4'h8);
		// program paused and resumed, then an erase
		i_array_busy <= 1'b1;
		pulse(6'h02);
		cmp_val("paused", 24'h1, {22'h0, o_status[15], o_status[10]});
		pulse(6'h04);
		pulse(6'h20);
		ask(0, 1, 0, a, 4'h8);
		pulse(6'h02);
		cmp_val("paused", 24'h2, {22'h0, o_status[15], o_status[10]});
		pulse(6'h04);
		cmp_val("paused", 24'h0, {22'h0, o_status[15], o_status[10]});
		i_array_busy <= 1'b0;
		spi(`FSP_CMD_WR_PERMIT, 0, 24'h0);
		cmp_val("wpl", 24'h1, {23'h0, o_status[1]});
		pulse(6'h30);
		cmp_val("fail", 24'h2, {22'h0, o_status[19], o_status[1]});
		// info lock sticks once set
		ask(1, 0, 0, 24'h0, 4'h2);
		wr(24'h004804);
		ask(1, 0, 0, 24'h0, 4'h1);
		wr(24'h004004);
		cmp_val("info lock", 24'h1, {23'h0, o_status[11]});
		ask(1, 0, 0, 24'h1, 4'h2);
		// pin mode, volatile write, supply lock
		wr(24'h000080);
		@(posedge i_clk_sys);
		i_wp_n <= 1'b0;
		wr(24'h000084);
		cmp_val("cfg", 24'h000880, o_status & 24'he37bfc);
		@(posedge i_clk_sys);
		i_wp_n <= 1'b1;
		spi(`FSP_CMD_VOL_PERMIT, 0, 24'h0);
		spi(`FSP_CMD_STATUS_WR, 3, 24'h000084);
		cmp_val("cfg", 24'h000884, o_status & 24'he37bfc);
		spi(`FSP_CMD_VOL_LOCK_WR, 1, 24'h000002);
		cmp_val("cfg", 24'h000904, o_status & 24'he37bfc);
		wr(24'h000000);
		cmp_val("cfg", 24'h000904, o_status & 24'he37bfc);
		pulse(6'h08);
		cmp_val("cfg", 24'h000804, o_status & 24'he37bfc);
		wr(24'h000a04);
		cmp_pins(4'h8);
		wr(24'h800804);
		cmp_pins(4'h5);
		// reset-role pin clears the guard error
		ask(0, 0, 0, 24'hffffff, 4'h4);
		i_hold_reset_n <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		cmp_val("guard err", 24'h0, {23'h0, o_status[18]});
		cmp_val("hold", 24'h1, {23'h0, o_hold_n});
		i_hold_reset_n <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		// one-time lock survives a power cycle
		spi(`FSP_CMD_VOL_LOCK_WR, 1, 24'h000003);
		wr(24'h000000);
		pulse(6'h08);
		cmp_val("cfg", 24'h800984, o_status & 24'he37bfc);
		cmp_val("pending", 24'h0, 24'(exp_q.size()));
		tally_and_finish;
	end
endmodule // fsp_status_bank_tb
